// ===== hdl/lpe_core.v
// Top: sixteen brightness PWMs, group dim/blink PWM, error latching, resets.
// Assumes sensor, load and I2C inputs are asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "lpe_defines.vh"
module lpe_core #(
	parameter CHANNELS       = 16,
	parameter DIM_STEP_CYC   = `LPE_DIM_STEP_CYC,
	parameter BLINK_STEP_CYC = `LPE_BLINK_STEP_CYC
) (
	// Clock and reset
	input  wire                  MCLK_IN,
	input  wire                  NRST_IN,
	// Control bits
	input  wire                  OSCILLATOR_OFF_IN,
	input  wire                  GROUP_DIM_BLINK_SELECT_IN,
	input  wire                  ERROR_FLAG_CLEAR_IN,
	input  wire [CHANNELS*8-1:0] PER_CHANNEL_DUTY_IN,
	input  wire [7:0]            GROUP_DUTY_IN,
	input  wire [7:0]            GROUP_FREQ_IN,
	input  wire [CHANNELS-1:0]   LED_ON_IN,
	input  wire [CHANNELS-1:0]   LED_PWM_IN,
	input  wire [CHANNELS-1:0]   LED_GROUP_IN,
	// Sensors
	input  wire [CHANNELS-1:0]   LOAD_OK_IN,
	input  wire                  GLOBAL_OVERTEMP_IN,
	input  wire [CHANNELS-1:0]   CHANNEL_OVERTEMP_IN,
	// I2C pins
	input  wire                  SCL_IN,
	input  wire                  SDA_IN,
	output reg                   SDA_OUT,
	output reg                   SDA_OE_OUT,
	// Results
	output reg  [CHANNELS-1:0]   LED_CHANNEL_OUT,
	output reg  [7:0]            ERROR_FLAGS_LOW_OUT,
	output reg  [7:0]            ERROR_FLAGS_HIGH_OUT,
	output reg                   SOFT_RESET_OUT
);
	localparam BRI_STEP = `LPE_BRI_STEP_CYC;

	////////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers on every asynchronous input
	localparam SW = 4 * CHANNELS + 2;
	reg  [SW-1:0] sync1_r;
	reg  [SW-1:0] sync2_r;
	wire [SW-1:0] async_w = {LOAD_OK_IN, CHANNEL_OVERTEMP_IN, LED_ON_IN, LED_PWM_IN,
		GLOBAL_OVERTEMP_IN, ERROR_FLAG_CLEAR_IN};
	reg           scl1_r, scl2_r, sda1_r, sda2_r;
	wire [CHANNELS-1:0] load_ok  = sync2_r[SW-1 -: CHANNELS];
	wire [CHANNELS-1:0] ch_ot    = sync2_r[3*CHANNELS+1 -: CHANNELS];
	wire [CHANNELS-1:0] led_on   = sync2_r[2*CHANNELS+1 -: CHANNELS];
	wire [CHANNELS-1:0] led_pwm  = sync2_r[CHANNELS+1 -: CHANNELS];
	wire                glob_ot  = sync2_r[1];
	wire                err_clr  = sync2_r[0];

	// Soft reset joins the pin reset; held one cycle through a register
	reg  soft_rst_r;
	wire rst_n = NRST_IN & ~soft_rst_r;
	wire bus_sda_oe;
	wire bus_reset;

	// The pulse output lives here so the internal reset it causes cannot erase it
	always @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			soft_rst_r <= 1'b0;
			SOFT_RESET_OUT <= 1'b0;
		end else begin
			soft_rst_r <= bus_reset;
			SOFT_RESET_OUT <= bus_reset;
		end
	end

	always @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= {SW{1'b0}};
			sync2_r <= {SW{1'b0}};
			scl1_r <= 1'b1;
			scl2_r <= 1'b1;
			sda1_r <= 1'b1;
			sda2_r <= 1'b1;
		end else begin
			sync1_r <= async_w;
			sync2_r <= sync1_r;
			scl1_r <= SCL_IN;
			scl2_r <= scl1_r;
			sda1_r <= SDA_IN;
			sda2_r <= sda1_r;
		end
	end

	lpe_bus_reset u_bus_reset (
		.clk           (MCLK_IN),
		.rst_n         (rst_n),
		.scl           (scl2_r),
		.sda           (sda2_r),
		.sda_oe_r      (bus_sda_oe),
		.reset_pulse_r (bus_reset)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Brightness modulator: 40 ns step, 256 steps, about 97 kHz
	reg [3:0] bri_pre_r;
	reg [7:0] bri_cnt_r;
	reg [7:0] grp_cnt_r;
	reg [23:0] grp_pre_r;
	reg       grp_sel_r;

	function duty_hi;
		input [7:0] cnt;
		input [7:0] duty;
		begin
			duty_hi = (cnt < duty);
		end
	endfunction

	// Blink step count scales with programmed frequency; dim uses fixed step
	wire [31:0] grp_lim_full = grp_sel_r ? (BLINK_STEP_CYC * ({24'h000000, GROUP_FREQ_IN}
		+ 32'h00000001) - 32'h00000001) : (DIM_STEP_CYC - 32'h00000001);
	// Longest blink step count fits in 24 bits
	wire [23:0] grp_lim = grp_lim_full[23:0];

	always @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			bri_pre_r <= 4'h0;
			bri_cnt_r <= 8'h00;
			grp_pre_r <= 24'h000000;
			grp_cnt_r <= 8'h00;
			grp_sel_r <= 1'b0;
		end else if (OSCILLATOR_OFF_IN) begin
			bri_pre_r <= 4'h0;
			bri_cnt_r <= 8'h00;
			grp_pre_r <= 24'h000000;
			grp_cnt_r <= 8'h00;
			grp_sel_r <= GROUP_DIM_BLINK_SELECT_IN;
		end else begin
			if (bri_pre_r == BRI_STEP - 1) begin
				bri_pre_r <= 4'h0;
				bri_cnt_r <= bri_cnt_r + 8'h01;
			end else begin
				bri_pre_r <= bri_pre_r + 4'h1;
			end
			if (grp_pre_r >= grp_lim) begin
				grp_pre_r <= 24'h000000;
				grp_cnt_r <= grp_cnt_r + 8'h01;
				// Mode change takes effect at a group period boundary, or at once while the oscillator is off
				if (grp_cnt_r == 8'hFF) begin
					grp_sel_r <= GROUP_DIM_BLINK_SELECT_IN;
				end
			end else begin
				grp_pre_r <= grp_pre_r + 24'h000001;
			end
		end
	end

	// One group waveform for all grouped channels
	wire grp_wave = duty_hi(grp_cnt_r, GROUP_DUTY_IN);

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel drive, errors
	reg  [CHANNELS-1:0] drive_nxt;
	reg  [CHANNELS-1:0] open_nxt;
	reg  [CHANNELS-1:0] ot_err_r;
	reg  [CHANNELS-1:0] open_err_r;
	reg  [CHANNELS-1:0] latch_on;
	reg  [7:0]          duty_i;
	integer i;

	always @* begin
		drive_nxt = {CHANNELS{1'b0}};
		open_nxt = {CHANNELS{1'b0}};
		latch_on = {CHANNELS{1'b0}};
		duty_i = 8'h00;
		for (i = 0; i < CHANNELS; i = i + 1) begin
			duty_i = PER_CHANNEL_DUTY_IN[i*8 +: 8];
			latch_on[i] = led_on[i] | led_pwm[i] | LED_GROUP_IN[i];
			if (led_on[i]) begin
				drive_nxt[i] = 1'b1;
			end else if (led_pwm[i]) begin
				drive_nxt[i] = duty_hi(bri_cnt_r, duty_i);
			end else if (LED_GROUP_IN[i]) begin
				drive_nxt[i] = duty_hi(bri_cnt_r, duty_i) & grp_wave;
			end
			// Thermal shutdown gates drive; it returns when sensors clear
			if (OSCILLATOR_OFF_IN || glob_ot || ch_ot[i]) begin
				drive_nxt[i] = 1'b0;
			end
			// Fully-on channel only; off or modulated reports 0
			open_nxt[i] = led_on[i] & drive_nxt[i] & ~load_ok[i];
		end
	end

	always @(posedge MCLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ot_err_r <= {CHANNELS{1'b0}};
			open_err_r <= {CHANNELS{1'b0}};
			LED_CHANNEL_OUT <= {CHANNELS{1'b0}};
			ERROR_FLAGS_LOW_OUT <= 8'h00;
			ERROR_FLAGS_HIGH_OUT <= 8'h00;
			SDA_OUT <= 1'b0;
			SDA_OE_OUT <= 1'b0;
		end else begin
			LED_CHANNEL_OUT <= drive_nxt;
			// A trip in the clear cycle wins over the clear
			ot_err_r <= (ot_err_r & {CHANNELS{~err_clr}})
				| ({CHANNELS{glob_ot}})
				| (ch_ot & latch_on);
			open_err_r <= open_nxt;
			// Flag bit 1 means normal, 0 means error or not checkable
			ERROR_FLAGS_LOW_OUT <= ~(ot_err_r[7:0] | open_err_r[7:0]
				| ~(led_on[7:0] & load_ok[7:0]));
			ERROR_FLAGS_HIGH_OUT <= ~(ot_err_r[15:8] | open_err_r[15:8]
				| ~(led_on[15:8] & load_ok[15:8]));
			SDA_OUT <= 1'b0;
			SDA_OE_OUT <= bus_sda_oe;
		end
	end
endmodule
`default_nettype wire

// ===== shared/lpe_defines.vh
// Constants for the LED PWM / error / reset core.
// Assumes a 200 MHz core clock; counts derive from that rate.
// What this block does
// - Sixteen channels each get a 97 kHz, 256-step brightness modulator.
// - Shared group modulator dims at fixed 190 Hz with 8-bit duty.
// - Blink mode: group period programmable by 8 bits, 24 Hz to 10.73 s.
// - One group duty and frequency applies to all grouped channels.
// - Only dimming or blinking signal is superimposed at any time.
// - Brightness steps are 40 ns; group dimming steps are 20.48 us.
// - Enabled channel current below threshold reports 0, normal reports 1.
// - Open-load checked only when channel on and not switching; off reports 0.
// - Global overtemperature turns all outputs off and flags every channel.
// - Channel overtemperature turns off that channel only, while it is on.
// - Outputs resume after sensor clears if channel latch still requests on.
// - Overtemperature error stays latched after sensor clears.
// - Each channel flag combines open-circuit and overtemperature into one bit.
// - Error clear bit at 1 clears latched overtemperature status of all channels.
// - Power-on reset loads all defaults, every channel deselected.
// - Reset pin low holds all state at defaults until released.
// - Acknowledge reset address 1101 011 only with write direction, D6h.
// - Acknowledge data A5h then 5Ah only; nothing beyond the second byte.
// - Correct sequence ended by Stop resets all state to power-up values.
// - Incorrect sequence format never causes a reset.
// - Select bit 0 chooses group dimming, 1 chooses group blinking.
// - Oscillator-off bit at 1 forces all channels off.
`ifndef LPE_DEFINES_VH
`define LPE_DEFINES_VH
`define LPE_CLK_MHZ        200
`define LPE_BRI_STEP_NS    40
`define LPE_DIM_STEP_NS    20480
`define LPE_BLINK_STEP_NS  163840
`define LPE_BRI_STEP_CYC   ((`LPE_BRI_STEP_NS * `LPE_CLK_MHZ) / 1000)
`define LPE_DIM_STEP_CYC   ((`LPE_DIM_STEP_NS * `LPE_CLK_MHZ) / 1000)
`define LPE_BLINK_STEP_CYC ((`LPE_BLINK_STEP_NS * `LPE_CLK_MHZ) / 1000)
`define LPE_I2C_ADDR_RST   8'hD6
`define LPE_I2C_DATA1      8'hA5
`define LPE_I2C_DATA2      8'h5A
`define LPE_DUTY_ZERO      8'h00
`define LPE_BIT_LAST       3'h7
`endif

// ===== hdl/lpe_bus_reset.v
// I2C listener for the bus reset call; answers only D6h, A5h, 5Ah.
// Assumes SCL/SDA are already synchronised to the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "lpe_defines.vh"
module lpe_bus_reset (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       scl,
	input  wire       sda,
	output reg        sda_oe_r,
	output reg        reset_pulse_r
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_D1   = 3'h2;
	localparam ST_D2   = 3'h3;
	localparam ST_OK   = 3'h4;
	localparam ST_DEAD = 3'h5;

	reg       scl_d_r;
	reg       sda_d_r;
	reg [2:0] state_r;
	reg [2:0] bit_r;
	reg [7:0] shift_r;
	reg       ack_phase_r;
	reg       ack_good_r;
	wire      scl_rise = scl & ~scl_d_r;
	wire      scl_fall = ~scl & scl_d_r;
	wire      start    = scl & scl_d_r & sda_d_r & ~sda;
	wire      stop     = scl & scl_d_r & ~sda_d_r & sda;
	wire [7:0] byte_in = {shift_r[6:0], sda};

	function match;
		input [2:0] st;
		input [7:0] b;
		begin
			case (st)
				ST_ADDR: match = (b == `LPE_I2C_ADDR_RST);
				ST_D1:   match = (b == `LPE_I2C_DATA1);
				ST_D2:   match = (b == `LPE_I2C_DATA2);
				default: match = 1'b0;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			state_r <= ST_IDLE;
			bit_r <= 3'h0;
			shift_r <= 8'h00;
			ack_phase_r <= 1'b0;
			ack_good_r <= 1'b0;
			sda_oe_r <= 1'b0;
			reset_pulse_r <= 1'b0;
		end else begin
			scl_d_r <= scl;
			sda_d_r <= sda;
			reset_pulse_r <= 1'b0;
			if (start) begin
				state_r <= ST_ADDR;
				bit_r <= 3'h0;
				ack_phase_r <= 1'b0;
				sda_oe_r <= 1'b0;
			end else if (stop) begin
				// Only a fully acknowledged sequence triggers the reset
				reset_pulse_r <= (state_r == ST_OK);
				state_r <= ST_IDLE;
				sda_oe_r <= 1'b0;
			end else if (scl_rise && !ack_phase_r && state_r != ST_IDLE) begin
				shift_r <= byte_in;
				bit_r <= bit_r + 3'h1;
				if (bit_r == `LPE_BIT_LAST) begin
					ack_phase_r <= 1'b1;
					ack_good_r <= match(state_r, byte_in);
				end
			end else if (scl_fall && ack_phase_r) begin
				// Drive ACK low from this falling edge to the next one
				if (sda_oe_r) begin
					sda_oe_r <= 1'b0;
					ack_phase_r <= 1'b0;
				end else begin
					sda_oe_r <= ack_good_r;
					if (!ack_good_r) begin
						state_r <= ST_DEAD;
						ack_phase_r <= 1'b0;
					end else begin
						case (state_r)
							ST_ADDR: state_r <= ST_D1;
							ST_D1:   state_r <= ST_D2;
							ST_D2:   state_r <= ST_OK;
							default: state_r <= ST_DEAD;
						endcase
					end
				end
			end else if (scl_fall && !ack_phase_r && state_r == ST_OK && bit_r != 3'h0) begin
				state_r <= ST_DEAD;
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/lpe_core_monitor.sv
// Assertion checker for lpe_core, bound to its ports.
// Assumes a single core clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lpe_core_monitor #(
	parameter CHANNELS = 16
) (
	input wire logic                MCLK_IN,
	input wire logic                NRST_IN,
	input wire logic                OSCILLATOR_OFF_IN,
	input wire logic [CHANNELS-1:0] LED_ON_IN,
	input wire logic [CHANNELS-1:0] LOAD_OK_IN,
	input wire logic                GLOBAL_OVERTEMP_IN,
	input wire logic [CHANNELS-1:0] CHANNEL_OVERTEMP_IN,
	input wire logic                SCL_IN,
	input wire logic                SDA_IN,
	input wire logic                SDA_OUT,
	input wire logic                SDA_OE_OUT,
	input wire logic [CHANNELS-1:0] LED_CHANNEL_OUT,
	input wire logic [7:0]          ERROR_FLAGS_LOW_OUT,
	input wire logic [7:0]          ERROR_FLAGS_HIGH_OUT,
	input wire logic                SOFT_RESET_OUT
);
	localparam C = CHANNELS;
	logic [4*C-1:0] on_p;
	logic [4*C-1:0] ld_p;
	logic [4*C-1:0] ot_p;
	logic [3:0]     stop_age;
	wire  [15:0]    flg = {ERROR_FLAGS_HIGH_OUT, ERROR_FLAGS_LOW_OUT};
	// History covers the input synchronisers, so late flag updates are not flagged
	wire  [C-1:0]   on_any = LED_ON_IN | on_p[C-1:0] | on_p[2*C-1:C] | on_p[3*C-1:2*C];
	wire  [C-1:0]   ld_any = LOAD_OK_IN | ld_p[C-1:0] | ld_p[2*C-1:C] | ld_p[3*C-1:2*C];
	wire  [C-1:0]   ot_all = CHANNEL_OVERTEMP_IN & ot_p[C-1:0] & ot_p[2*C-1:C] & ot_p[4*C-1:3*C];
	always @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			on_p <= '0;
			ld_p <= '0;
			ot_p <= '0;
			stop_age <= 4'hF;
		end else begin
			on_p <= {on_p[3*C-1:0], LED_ON_IN};
			ld_p <= {ld_p[3*C-1:0], LOAD_OK_IN};
			ot_p <= {ot_p[3*C-1:0], CHANNEL_OVERTEMP_IN};
			if (SCL_IN && $rose(SDA_IN))
				stop_age <= 4'h0;
			else if (stop_age != 4'hF)
				stop_age <= stop_age + 4'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!NRST_IN);
	sequence s_stop;
		SCL_IN && $rose(SDA_IN);
	endsequence
	sequence s_cleared;
		!SOFT_RESET_OUT && LED_CHANNEL_OUT == '0 && flg == 16'h0000;
	endsequence
	AST_RESET_VAL: assert property (disable iff (1'b0) $rose(NRST_IN) |-> s_cleared)
		else $error("outputs not at defaults after reset");
	AST_OSC_OFF: assert property (OSCILLATOR_OFF_IN [*3] |-> LED_CHANNEL_OUT == '0)
		else $error("led driven with oscillator off");
	AST_GLOBAL_OT: assert property (GLOBAL_OVERTEMP_IN [*5] |-> s_cleared)
		else $error("global overtemperature not applied");
	AST_CH_OT: assert property ((ot_all & (LED_CHANNEL_OUT | flg)) == '0)
		else $error("hot channel still driven or flagged normal");
	AST_FLAG_CAUSE: assert property ((flg & ~(on_any & ld_any)) == '0)
		else $error("flag normal without full-on channel and good load");
	AST_SDA_LOW: assert property (SDA_OUT == 1'b0)
		else $error("sda driven high");
	AST_ACK_SCL_LOW: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
		else $error("ack changed while clock high");
	AST_SOFT_PULSE: assert property (SOFT_RESET_OUT |=> s_cleared)
		else $error("bus reset did not clear state");
	AST_SOFT_STOP: assert property (SOFT_RESET_OUT |-> stop_age <= 4'h9)
		else $error("bus reset without a recent stop");
	cover property (s_stop ##[1:10] SOFT_RESET_OUT);
endmodule
bind lpe_core lpe_core_monitor #(.CHANNELS(CHANNELS)) mon_u (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN),
	.OSCILLATOR_OFF_IN(OSCILLATOR_OFF_IN), .LED_ON_IN(LED_ON_IN), .LOAD_OK_IN(LOAD_OK_IN),
	.GLOBAL_OVERTEMP_IN(GLOBAL_OVERTEMP_IN), .CHANNEL_OVERTEMP_IN(CHANNEL_OVERTEMP_IN),
	.SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT),
	.LED_CHANNEL_OUT(LED_CHANNEL_OUT), .ERROR_FLAGS_LOW_OUT(ERROR_FLAGS_LOW_OUT),
	.ERROR_FLAGS_HIGH_OUT(ERROR_FLAGS_HIGH_OUT), .SOFT_RESET_OUT(SOFT_RESET_OUT));
`default_nettype wire

// ===== testbench/lpe_i2c_host.sv
// Bus master model driving the I2C pins with an 80 ns bit period.
// Assumes the bench resolves SDA from both drivers and a pull-up.
`timescale 1ns/1ps
`default_nettype none
module lpe_i2c_host (
	output var logic scl,
	output var logic sda_drv,
	input  wire logic sda_line
);
	// Clock stands high between frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic start();
		sda_drv = 1'b0;
		#40 scl = 1'b0;
	endtask
	// Keeps sending after a refusal so the device must keep refusing
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#20 sda_drv = b[i];
			#20 scl = 1'b1;
			#40 scl = 1'b0;
		end
		#20 sda_drv = 1'b1;
		#20 scl = 1'b1;
		#20 ack = !sda_line;
		#20 scl = 1'b0;
	endtask
	task automatic stop();
		#20 sda_drv = 1'b0;
		#20 scl = 1'b1;
		#40 sda_drv = 1'b1;
		#600;
	endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for lpe_core: errors, PWM, group and bus reset tests.
// Assumes the host model and the bound monitor; group steps are shortened.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic         MCLK_IN = 1'b0;
	logic         NRST_IN = 1'b0;
	logic         OSCILLATOR_OFF_IN = 1'b0;
	logic         GROUP_DIM_BLINK_SELECT_IN = 1'b0;
	logic         ERROR_FLAG_CLEAR_IN = 1'b0;
	logic [127:0] PER_CHANNEL_DUTY_IN = '0;
	logic [7:0]   GROUP_DUTY_IN = 8'h00;
	logic [7:0]   GROUP_FREQ_IN = 8'h00;
	logic [15:0]  LED_ON_IN = '0, LED_PWM_IN = '0, LED_GROUP_IN = '0;
	logic [15:0]  LOAD_OK_IN = 16'hFFFF, CHANNEL_OVERTEMP_IN = '0;
	logic         GLOBAL_OVERTEMP_IN = 1'b0;
	wire logic    SCL_IN, SDA_IN, sda_drv, SDA_OUT, SDA_OE_OUT, SOFT_RESET_OUT;
	wire logic [15:0] LED_CHANNEL_OUT;
	wire logic [7:0]  ERROR_FLAGS_LOW_OUT, ERROR_FLAGS_HIGH_OUT;
	wire logic [15:0] flg = {ERROR_FLAGS_HIGH_OUT, ERROR_FLAGS_LOW_OUT};
	int n_fail = 0, compares = 0, n_rst = 0;
	// Open-drain SDA with a pull-up
	assign SDA_IN = sda_drv & ~SDA_OE_OUT;
	always #2.5 MCLK_IN = ~MCLK_IN;
	always @(posedge MCLK_IN) if (SOFT_RESET_OUT === 1'b1) n_rst++;
	lpe_i2c_host host_u (.scl(SCL_IN), .sda_drv(sda_drv), .sda_line(SDA_IN));
	lpe_core #(.DIM_STEP_CYC(4), .BLINK_STEP_CYC(8)) dut_u (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN),
		.OSCILLATOR_OFF_IN(OSCILLATOR_OFF_IN), .GROUP_DIM_BLINK_SELECT_IN(GROUP_DIM_BLINK_SELECT_IN),
		.ERROR_FLAG_CLEAR_IN(ERROR_FLAG_CLEAR_IN), .PER_CHANNEL_DUTY_IN(PER_CHANNEL_DUTY_IN),
		.GROUP_DUTY_IN(GROUP_DUTY_IN), .GROUP_FREQ_IN(GROUP_FREQ_IN), .LED_ON_IN(LED_ON_IN),
		.LED_PWM_IN(LED_PWM_IN), .LED_GROUP_IN(LED_GROUP_IN), .LOAD_OK_IN(LOAD_OK_IN),
		.GLOBAL_OVERTEMP_IN(GLOBAL_OVERTEMP_IN), .CHANNEL_OVERTEMP_IN(CHANNEL_OVERTEMP_IN),
		.SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT),
		.LED_CHANNEL_OUT(LED_CHANNEL_OUT), .ERROR_FLAGS_LOW_OUT(ERROR_FLAGS_LOW_OUT),
		.ERROR_FLAGS_HIGH_OUT(ERROR_FLAGS_HIGH_OUT), .SOFT_RESET_OUT(SOFT_RESET_OUT));
	////////////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK_IN);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic clear_err();
		ERROR_FLAG_CLEAR_IN <= 1'b1;
		cyc(8);
		ERROR_FLAG_CLEAR_IN <= 1'b0;
		cyc(8);
	endtask
	// Counts high cycles of channels 0 and 1 and the longest low run of channel 0
	task automatic meas(input int n, output int c0, output int c1, output int run);
		int r = 0;
		c0 = 0;
		c1 = 0;
		run = 0;
		repeat (n) begin
			@(posedge MCLK_IN);
			c0 += (LED_CHANNEL_OUT[0] === 1'b1);
			c1 += (LED_CHANNEL_OUT[1] === 1'b1);
			r = (LED_CHANNEL_OUT[0] === 1'b1) ? 0 : r + 1;
			if (r > run) run = r;
		end
	endtask
	task automatic t_err();
		LED_ON_IN <= 16'h0003;
		LOAD_OK_IN <= 16'h0001;
		cyc(10);
		chk("flags_load", flg, 16'h0001);
		LOAD_OK_IN <= 16'h0003;
		CHANNEL_OVERTEMP_IN <= 16'h0001;
		cyc(10);
		chk("led_chot", LED_CHANNEL_OUT, 16'h0002);
		chk("flags_chot", flg, 16'h0002);
		CHANNEL_OVERTEMP_IN <= 16'h0000;
		cyc(10);
		chk("led_cool", LED_CHANNEL_OUT, 16'h0003);
		chk("flags_held", flg, 16'h0002);
		clear_err();
		chk("flags_clr", flg, 16'h0003);
		GLOBAL_OVERTEMP_IN <= 1'b1;
		cyc(10);
		chk("led_got", LED_CHANNEL_OUT, 16'h0000);
		chk("flags_got", flg, 16'h0000);
		GLOBAL_OVERTEMP_IN <= 1'b0;
		cyc(10);
		chk("led_gcool", LED_CHANNEL_OUT, 16'h0003);
		chk("flags_gheld", flg, 16'h0000);
		clear_err();
		OSCILLATOR_OFF_IN <= 1'b1;
		cyc(10);
		chk("led_osc", LED_CHANNEL_OUT, 16'h0000);
		OSCILLATOR_OFF_IN <= 1'b0;
		$display("test errors done");
	endtask
	task automatic t_pwm();
		int c0, c1, run;
		LED_ON_IN <= '0;
		LED_PWM_IN <= 16'h0003;
		PER_CHANNEL_DUTY_IN[15:0] <= 16'hFF40;
		cyc(20);
		meas(2048, c0, c1, run);
		chk("duty_40", 16'(c0), 16'd512);
		chk("duty_ff", 16'(c1), 16'd2040);
		PER_CHANNEL_DUTY_IN[7:0] <= 8'h00;
		cyc(20);
		meas(2048, c0, c1, run);
		chk("duty_00", 16'(c0), 16'd0);
		$display("test pwm done");
	endtask
	task automatic t_group();
		int c0, c1, run;
		LED_PWM_IN <= '0;
		LED_GROUP_IN <= 16'h0003;
		PER_CHANNEL_DUTY_IN[15:0] <= 16'hFFFF;
		cyc(4200);
		meas(8192, c0, c1, run);
		chk("grp_zero", 16'(c0), 16'd0);
		GROUP_DUTY_IN <= 8'h40;
		cyc(4200);
		meas(8192, c0, c1, run);
		chk("dim_high", 16'(c0 >= 2016 && c0 <= 2048), 16'd1);
		chk("grp_same", 16'(c0), 16'(c1));
		chk("dim_run", 16'(run >= 768 && run <= 776), 16'd1);
		GROUP_DIM_BLINK_SELECT_IN <= 1'b1;
		GROUP_FREQ_IN <= 8'h01;
		cyc(4200);
		meas(8192, c0, c1, run);
		chk("blink_high", 16'(c0 >= 2016 && c0 <= 2048), 16'd1);
		chk("blink_run", 16'(run >= 3072 && run <= 3080), 16'd1);
		$display("test group done");
	endtask
	task automatic bus_call(input logic [31:0] b, input int n, input logic [3:0] exp_ack,
		input int exp_rst);
		logic [3:0] ack = '0;
		int r0 = n_rst;
		#1 host_u.start();
		for (int i = 0; i < n; i++) host_u.put_byte(b[31-8*i -: 8], ack[3-i]);
		host_u.stop();
		@(posedge MCLK_IN);
		chk("ack", ack, exp_ack);
		chk("resets", 16'(n_rst - r0), 16'(exp_rst));
	endtask
	task automatic t_bus();
		LED_ON_IN <= 16'h0003;
		CHANNEL_OVERTEMP_IN <= 16'h0001;
		cyc(10);
		CHANNEL_OVERTEMP_IN <= 16'h0000;
		cyc(10);
		bus_call(32'hD7000000, 1, 4'b0000, 0);
		bus_call(32'hD6000000, 2, 4'b1000, 0);
		bus_call(32'hD6A50000, 3, 4'b1100, 0);
		bus_call(32'hD6A55AFF, 4, 4'b1110, 0);
		chk("flags_kept", flg, 16'h0002);
		bus_call(32'hD6A55A00, 3, 4'b1110, 1);
		cyc(10);
		chk("flags_reset", flg, 16'h0003);
		$display("test bus reset done");
	endtask
	initial begin
		cyc(2);
		chk("led_rst", LED_CHANNEL_OUT, 16'h0000);
		chk("flags_rst", flg, 16'h0000);
		NRST_IN <= 1'b1;
		cyc(4);
		t_err();
		t_pwm();
		t_group();
		t_bus();
		end_sim();
	end
	initial begin
		cyc(90000);
		n_fail++;
		$display("ERROR timeout expected 0 seen 1");
		end_sim();
	end
endmodule
`default_nettype wire
